//--- bench/acc_ana_src.sv
// Analog source model feeding the comparator decision
`timescale 1ns/1ps
`default_nettype none
module acc_ana_src (
  input wire logic [9:0] dacTrial,
  input wire logic [9:0] level,
  output logic cmpHigh
);
  // Input at or above the trial code
  assign cmpHigh = (level >= dacTrial);
endmodule
`default_nettype wire

//--- bench/acc_conv_ctrl_tb.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_tb;
  import acc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] modeWrData = 8'h00;
  logic modeWrEn = 1'b0;
  logic [1:0] chanWrData = 2'h0;
  logic chanWrEn = 1'b0;
  logic doneFlagClr = 1'b0;
  logic resultRdEn = 1'b0;
  logic cmpHigh;
  logic [9:0] level = 10'h2b6;
  logic [7:0] modeReg;
  logic [1:0] chanReg;
  logic [9:0] resWord;
  logic [7:0] resHigh;
  logic doneFlag;
  logic endIrq;
  logic suspect;
  logic cmpOn;
  logic [9:0] trial;
  int failures = 0;
  int n_compared = 0;
  int n3;
  int n4;

  // Clock, 50 ns period
  always #25 sys_clk = ~sys_clk;

  acc_conv_ctrl #(.SETTLE_CYCLES(2)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .modeWrData(modeWrData), .modeWrEn(modeWrEn),
    .chanWrData(chanWrData), .chanWrEn(chanWrEn), .doneFlagClr(doneFlagClr),
    .resultRdEn(resultRdEn), .cmpHigh(cmpHigh), .converter_mode_reg(modeReg),
    .channel_select_reg(chanReg), .result_word_reg(resWord),
    .result_high_byte_reg(resHigh), .conversion_done_flag(doneFlag),
    .conversion_end_irq(endIrq), .firstSuspect(suspect), .comparatorOn(cmpOn),
    .dacTrial(trial)
  );

  acc_ana_src src_u (.dacTrial(trial), .level(level), .cmpHigh(cmpHigh));

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wrMode(input logic [7:0] d);
    @(negedge sys_clk);
    modeWrData = d;
    modeWrEn = 1'b1;
    @(negedge sys_clk);
    modeWrEn = 1'b0;
  endtask

  // Bounded wait for the end pulse, cycles counted
  task automatic waitIrq(output int n);
    n = 0;
    while (endIrq !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 2000) chk(16'h0, 16'h1);
  endtask

  // Waiting mode, then timed conversions at two speeds
  task automatic scnConvert();
    wrMode(8'h01);
    repeat (40) @(negedge sys_clk);
    chk({15'h0, cmpOn}, 16'h1);
    chk({15'h0, endIrq | doneFlag}, 16'h0);
    wrMode(8'ha1);
    waitIrq(n4);
    chk({6'h0, resWord}, {6'h0, level});
    chk({8'h0, resHigh}, {8'h0, level[9:2]});
    chk({15'h0, doneFlag}, 16'h1);
    chk({15'h0, suspect}, 16'h0);
    @(negedge sys_clk);
    chk({15'h0, endIrq}, 16'h0);
    doneFlagClr = 1'b1;
    @(negedge sys_clk);
    doneFlagClr = 1'b0;
    chk({15'h0, doneFlag}, 16'h0);
    wrMode(8'h99);
    waitIrq(n3);
    chk(16'(n3 - n4), 16'd10);
  endtask

  // Channel write landing on a conversion end keeps the flag, drops the end
  task automatic scnChannel();
    repeat (21) @(negedge sys_clk);
    chanWrData = 2'h3;
    chanWrEn = 1'b1;
    @(negedge sys_clk);
    chanWrEn = 1'b0;
    chk({15'h0, endIrq}, 16'h0);
    chk({15'h0, doneFlag}, 16'h1);
    chk({14'h0, chanReg}, 16'h3);
    chk({6'h0, resWord}, 16'h0);
  endtask

  // Read held across a conversion end defers the store
  task automatic scnReadHold();
    waitIrq(n3);
    @(negedge sys_clk);
    resultRdEn = 1'b1;
    level = 10'h155;
    repeat (2 * n4 + 40) @(negedge sys_clk);
    chk({6'h0, resWord}, 16'h2b6);
    resultRdEn = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({6'h0, resWord}, 16'h155);
  endtask

  // Start with enable low marks the first result
  task automatic scnEarly();
    wrMode(8'h00);
    wrMode(8'ha0);
    waitIrq(n3);
    chk({15'h0, suspect}, 16'h1);
  endtask

  // Watchdog
  initial begin
    #(20000 * 50);
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk({doneFlag, endIrq, 4'h0, resWord}, 16'h0);
    chk({8'h0, modeReg}, {8'h0, MODE_RESET});
    scnConvert();
    scnChannel();
    scnReadHold();
    scnEarly();
    summarize();
  end
endmodule
`default_nettype wire

//--- src/acc_conv_ctrl.sv
// Conversion control for a four-channel successive-approximation converter
//
// How it works
// - Channel write leaves done flag untouched
// - Old-channel result may land before rewrite
// - Early start marks first result suspect
// - Mode or channel write spoils results
// - Enable without start gives waiting mode
// - Result read defers pending store
// - Register write beats conversion end
// - Bits 5..3 select conversion time
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = acc_pkg::SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] modeWrData,
  input wire logic modeWrEn,
  input wire logic [1:0] chanWrData,
  input wire logic chanWrEn,
  input wire logic doneFlagClr,
  input wire logic resultRdEn,
  input wire logic cmpHigh,
  output logic [7:0] converter_mode_reg,
  output logic [1:0] channel_select_reg,
  output logic [acc_pkg::RES_W-1:0] result_word_reg,
  output logic [7:0] result_high_byte_reg,
  output logic conversion_done_flag,
  output logic conversion_end_irq,
  output logic firstSuspect,
  output logic comparatorOn,
  output logic [acc_pkg::RES_W-1:0] dacTrial
);
  import acc_pkg::*;

  // Step period in cycles per selector code
  function automatic logic [7:0] convPeriod(input logic [2:0] sel);
    convPeriod = 8'(CONV_BASE_CYC) >> sel;
  endfunction

  acc_state_t state_q, state_d;
  logic [7:0] mode_q, mode_d;
  logic [1:0] chan_q, chan_d;
  logic [RES_W-1:0] res_q, res_d, pend_q, pend_d;
  logic pendV_q, pendV_d, flag_q, flag_d, irq_q, irq_d, sus_q, sus_d, cmpOn_q;
  logic [15:0] settle_q, settle_d;
  logic [7:0] div_q, div_d;
  logic coreGo, coreAbort, coreStep, coreBusy, coreDone, regWr, startBit, enBit;
  logic [RES_W-1:0] coreTrial;

  assign startBit = mode_q[MODE_START_BIT];
  assign enBit = mode_q[MODE_ENABLE_BIT];
  assign regWr = modeWrEn | chanWrEn;

  // Step divider paced by the time selector
  always_comb begin
    coreStep = 1'b0;
    div_d = div_q;
    if (!coreBusy || coreGo) begin
      div_d = 8'h00;
    end else if (div_q + 8'h01 >= convPeriod(mode_q[MODE_TSEL_LSB +: MODE_TSEL_W])) begin
      div_d = 8'h00;
      coreStep = 1'b1;
    end else begin
      div_d = div_q + 8'h01;
    end
  end

  // Mode state, restarts, settle tracking and result handling
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    chan_d = chan_q;
    res_d = res_q;
    pend_d = pend_q;
    pendV_d = pendV_q;
    flag_d = flag_q;
    irq_d = 1'b0;
    sus_d = sus_q;
    settle_d = settle_q;
    coreGo = 1'b0;
    coreAbort = 1'b0;
    if (modeWrEn) mode_d = modeWrData;
    if (chanWrEn) chan_d = chanWrData; // flag not touched here
    // Settle counter restarts when enable rises
    if (!enBit) settle_d = 16'h0000;
    else if (settle_q < 16'(SETTLE_CYCLES)) settle_d = settle_q + 16'h0001;
    // Waiting mode when enabled but not started
    unique case (state_q)
      ACC_OFF: if (enBit) state_d = ACC_WAIT;
      ACC_WAIT: if (!enBit) state_d = ACC_OFF;
      ACC_CONV: if (!startBit) state_d = enBit ? ACC_WAIT : ACC_OFF;
    endcase
    if (modeWrEn && modeWrData[MODE_START_BIT] && !startBit) begin
      // Early start or start while disabled
      sus_d = !enBit || !modeWrData[MODE_ENABLE_BIT] || settle_q < 16'(SETTLE_CYCLES);
    end
    // Any write aborts the conversion, restarts it if start is set, and spoils results
    if (regWr) begin
      coreAbort = 1'b1;
      res_d = '0;
      pendV_d = 1'b0;
      if ((modeWrEn ? modeWrData[MODE_START_BIT] : startBit)) state_d = ACC_CONV;
    end else if (state_q == ACC_CONV && startBit && !coreBusy && !coreDone) begin
      coreGo = 1'b1;
    end
    // Conversion end, dropped if a register write collides
    if (coreDone && !regWr && state_q == ACC_CONV) begin
      if (resultRdEn) begin
        pend_d = coreTrial;
        pendV_d = 1'b1;
      end else begin
        res_d = coreTrial;
        pendV_d = 1'b0; // A fresh store outranks an older deferred one
      end
      flag_d = 1'b1;
      irq_d = 1'b1;
      if (sus_q && !resultRdEn) sus_d = sus_q;
    end else if (pendV_q && !resultRdEn && !regWr) begin
      res_d = pend_q;
      pendV_d = 1'b0;
    end
    if (doneFlagClr && !(coreDone && !regWr && state_q == ACC_CONV)) flag_d = 1'b0;
  end

  acc_sar_core #(
    .RES_W(RES_W)
  ) u_core (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .go(coreGo),
    .abort(coreAbort),
    .stepEn(coreStep),
    .cmpHigh(cmpHigh),
    .trial(coreTrial),
    .busy(coreBusy),
    .doneP(coreDone)
  );

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ACC_OFF;
      mode_q <= MODE_RESET;
      chan_q <= CHAN_RESET;
      res_q <= RESULT_RESET;
      pend_q <= RESULT_RESET;
      pendV_q <= 1'b0;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      sus_q <= 1'b0;
      settle_q <= 16'h0000;
      div_q <= 8'h00;
      cmpOn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      chan_q <= chan_d;
      res_q <= res_d;
      pend_q <= pend_d;
      pendV_q <= pendV_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      sus_q <= sus_d;
      settle_q <= settle_d;
      div_q <= div_d;
      cmpOn_q <= (state_d != ACC_OFF);
    end
  end

  // Outputs straight from their registers
  assign converter_mode_reg = mode_q;
  assign channel_select_reg = chan_q;
  assign result_word_reg = res_q;
  assign result_high_byte_reg = res_q[RES_W-1 -: 8];
  assign conversion_done_flag = flag_q;
  assign conversion_end_irq = irq_q;
  assign firstSuspect = sus_q;
  assign comparatorOn = cmpOn_q;
  assign dacTrial = coreTrial; // Core trial flop, so the comparator never lags a step

  // Checks
  a_chan_keeps_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    chanWrEn && !modeWrEn && !doneFlagClr && flag_q |=> flag_q)
    else $error("channel write cleared done flag");
  a_write_blocks_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWr |=> !irq_q)
    else $error("irq raised on colliding write");
  a_end_sets_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(irq_q) |-> flag_q)
    else $error("irq without done flag");
  a_write_spoils_res: assert property (@(posedge sys_clk) disable iff (!rst_n)
    regWr |=> res_q == RESULT_RESET)
    else $error("result kept after mode or channel write");
  a_read_defers_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    coreDone && resultRdEn && !regWr && state_q == ACC_CONV |=> $stable(res_q) && pendV_q)
    else $error("store not deferred during read");
  a_wait_mode_cmp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ACC_WAIT |-> comparatorOn && !coreBusy && !startBit)
    else $error("waiting mode wrong");
  a_early_start_sus: assert property (@(posedge sys_clk) disable iff (!rst_n)
    modeWrEn && modeWrData[MODE_START_BIT] && !startBit && !enBit |=> sus_q)
    else $error("early start not marked");
  a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    coreDone && !regWr && state_q == ACC_CONV |=> flag_q)
    else $error("done flag lost");
  c_conv_end: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_q);
  c_read_collide: cover property (@(posedge sys_clk) disable iff (!rst_n)
    coreDone && resultRdEn);
  c_write_collide: cover property (@(posedge sys_clk) disable iff (!rst_n) coreDone && regWr);
  c_wait_mode: cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == ACC_WAIT);
endmodule
`default_nettype wire

//--- src/acc_pkg.sv
// Package of constants for the converter conversion control block
package acc_pkg;
  // Mode register field positions
  localparam int unsigned MODE_START_BIT = 7;
  localparam int unsigned MODE_ENABLE_BIT = 0;
  localparam int unsigned MODE_TSEL_LSB = 3;
  localparam int unsigned MODE_TSEL_W = 3;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // Settling time after enable, in ns, and the least cycle count
  localparam int unsigned SYS_CLK_HZ = 20000000;
  localparam int unsigned SETTLE_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  // Step period at selector code 0, in clock cycles, halved per code down to one cycle at codes 4 to 7
  localparam int unsigned CONV_BASE_CYC = 16;
  localparam int unsigned RES_W = 10;
  typedef enum logic [1:0] {
    ACC_OFF = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_CONV = 2'b10
  } acc_state_t;
endpackage

//--- src/acc_sar_core.sv
// Successive-approximation step engine for one conversion
`timescale 1ns/1ps
`default_nettype none
module acc_sar_core #(
  parameter int unsigned RES_W = 10
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic abort,
  input wire logic stepEn,
  input wire logic cmpHigh,
  output logic [RES_W-1:0] trial,
  output logic busy,
  output logic doneP
);
  logic [RES_W-1:0] trial_q, trial_d, bit_q, bit_d;
  logic busy_q, busy_d, done_q, done_d;

  // Bit walk from MSB to LSB, one bit per step
  always_comb begin
    trial_d = trial_q;
    bit_d = bit_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (abort) begin
      busy_d = 1'b0;
    end else if (go) begin
      busy_d = 1'b1;
      bit_d = {1'b1, {(RES_W-1){1'b0}}};
      trial_d = {1'b1, {(RES_W-1){1'b0}}};
    end else if (busy_q && stepEn) begin
      if (!cmpHigh) trial_d = trial_q & ~bit_q;
      bit_d = bit_q >> 1;
      trial_d = trial_d | (bit_q >> 1);
      if (bit_q[0]) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q <= '0;
      bit_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      trial_q <= trial_d;
      bit_q <= bit_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign trial = trial_q;
  assign busy = busy_q;
  assign doneP = done_q;
endmodule
`default_nettype wire
